// >>> rtl/host_port_pkg.sv
// Purpose: shared constants for the framer host bus port
// Assumes: one 50 MHz clock stands in for the processor and internal clocks
// Notes: register map holds the two documented registers plus a small store
// Functional notes
// - reset release restores defaults, I/O to input
// - power-on reset does same initialisation
// - internal clock mode ignores processor clock
// - external clock tick paces register writes only; strobe sampling runs every clock
// - style 0: separate address, data, strobe, direction
// - style 1: muxed address/data, read/write strobes
// - async mode: strobes control output, write synchronised
// - sync mode samples strobes on clock edge
// - sync separate-bus cycles need no waits
// - address strobe falling edge latches address
// - select high ends cycle, floats data bus
// - sync separate-bus with external clock drives transfer acknowledge
// - interrupt request driven while any pending
package host_port_pkg;
	localparam int ADDR_W = 9;
	localparam int DATA_W = 8;
	localparam logic [8:0] SOFT_RESET_OFS = 9'h001;
	localparam logic [8:0] PIO_DIR_OFS = 9'h018;
	localparam logic [7:0] SOFT_RESET_RST = 8'h00;
	localparam logic [7:0] PIO_DIR_RST = 8'h00;
	localparam logic [7:0] STORE_RST = 8'h00;
	localparam int POR_CYCLES = 4;
	localparam logic [2:0] POR_LAST = 3'h3;
	localparam int SYNC_STAGES = 2;
endpackage

// >>> rtl/strobe_sync.sv
// Purpose: two-stage synchroniser for host control inputs
// Assumes: inputs may change at any time relative to the clock
// Notes: the first stage feeds only the second stage
`timescale 1ns/10ps
`default_nettype none
module strobe_sync #(
	parameter int WIDTH = 4
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// levels
	input wire logic [WIDTH-1:0] d_in,
	input wire logic [WIDTH-1:0] rst_val_in,
	output logic [WIDTH-1:0] q_out
);
	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] q_r;

	// per-bit two-flop chain, idle level after reset is all ones
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge clk_in or posedge rst_in) begin
				if (rst_in) begin
					meta_r[i] <= 1'b1;
					q_r[i] <= 1'b1;
				end else begin
					meta_r[i] <= d_in[i];
					q_r[i] <= meta_r[i];
				end
			end
		end
	endgenerate

	assign q_out = q_r;
endmodule
`default_nettype wire

// >>> rtl/framer_host_bus_port.sv
// Purpose: parallel 8-bit host port with register file
// Assumes: processor clock pin already selected onto clk_in when external
// Notes: data bus is three signals, enable high while driving
`timescale 1ns/10ps
`default_nettype none
module framer_host_bus_port #(
	parameter int STORE_DEPTH = 32
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic hw_reset_n_in,
	// straps
	input wire logic bus_style_select_in,
	input wire logic sync_bus_select_in,
	input wire logic clock_source_select_in,
	input wire logic proc_clk_tick_in,
	// host bus
	input wire logic [8:0] addr_in,
	input wire logic [7:0] ad_in,
	output logic [7:0] ad_out,
	output logic ad_oe_out,
	input wire logic address_latch_strobe_n_in,
	input wire logic chip_select_n_in,
	input wire logic data_strobe_n_in,
	input wire logic rd_wr_n_in,
	// open-drain outputs
	output logic transfer_ack_n_out,
	output logic transfer_ack_oe_out,
	output logic interrupt_request_n_out,
	output logic interrupt_request_oe_out,
	// block side
	input wire logic [7:0] irq_pending_in,
	output logic [7:0] programmable_io_dir_out,
	output logic [7:0] soft_reset_out
);
	// synchronised controls: {as, cs, ds, rw}
	logic [3:0] raw_ctl;
	logic [3:0] ctl;
	assign raw_ctl = {address_latch_strobe_n_in, chip_select_n_in, data_strobe_n_in, rd_wr_n_in};

	strobe_sync #(.WIDTH(4)) u_sync (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.d_in(raw_ctl),
		.rst_val_in(4'hF),
		.q_out(ctl)
	);

	logic as_n, cs_n, ds_n, rw_n;
	assign as_n = ctl[3];
	assign cs_n = ctl[2];
	assign ds_n = ctl[1];
	assign rw_n = ctl[0];

	// power-on reset and hardware reset release
	logic [2:0] por_cnt_r, por_cnt_nxt;
	logic hw_n_q_r, hw_n_q_nxt;
	logic hw_n_d_r, hw_n_d_nxt;
	logic init_pulse;

	always_comb begin
		por_cnt_nxt = por_cnt_r;
		if (por_cnt_r != host_port_pkg::POR_LAST) begin
			por_cnt_nxt = por_cnt_r + 3'h1;
		end
		hw_n_q_nxt = hw_reset_n_in;
		hw_n_d_nxt = hw_n_q_r;
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			por_cnt_r <= 3'h0;
			hw_n_q_r <= 1'b1;
			hw_n_d_r <= 1'b1;
		end else begin
			por_cnt_r <= por_cnt_nxt;
			hw_n_q_r <= hw_n_q_nxt;
			hw_n_d_r <= hw_n_d_nxt;
		end
	end

	// rising edge after one sampled low cycle, or power-on count reaching 2, one before POR_LAST
	assign init_pulse = (hw_n_q_r & ~hw_n_d_r) | (por_cnt_r == 3'h2);

	// clock enable: internal mode runs every cycle, external uses tick
	logic tick;
	assign tick = clock_source_select_in ? proc_clk_tick_in : 1'b1;
	logic sync_mode;
	assign sync_mode = sync_bus_select_in & clock_source_select_in;

	// address latch state
	logic as_d_r, as_d_nxt;
	logic [8:0] addr_r, addr_nxt;
	// cycle state
	logic wr_done_r, wr_done_nxt;
	logic [7:0] wdata_r, wdata_nxt;

	// strobe decode per bus style
	logic rd_req, wr_req, cyc_ok;
	always_comb begin
		if (bus_style_select_in) begin
			rd_req = ~ds_n;
			wr_req = ~rw_n;
		end else begin
			rd_req = ~ds_n & rw_n;
			wr_req = ~ds_n & ~rw_n;
		end
		cyc_ok = ~cs_n & (~sync_mode | ~as_n);
	end

	// address capture on falling strobe, address store
	always_comb begin
		as_d_nxt = as_n;
		addr_nxt = addr_r;
		if (as_d_r & ~as_n) begin
			if (bus_style_select_in) begin
				addr_nxt = {addr_in[8], ad_in};
			end else begin
				addr_nxt = addr_in;
			end
		end
	end

	// register file
	logic [7:0] soft_r, soft_nxt;
	logic [7:0] pio_r, pio_nxt;
	logic [7:0] store_r [STORE_DEPTH];
	logic [7:0] rd_val;
	logic wr_fire;

	assign wr_fire = tick & cyc_ok & wr_req & ~wr_done_r;

	always_comb begin
		wr_done_nxt = wr_done_r;
		wdata_nxt = wdata_r;
		if (!(cyc_ok & wr_req)) begin
			wr_done_nxt = 1'b0;
		end else if (wr_fire) begin
			wr_done_nxt = 1'b1;
		end
		if (cyc_ok & wr_req) begin
			wdata_nxt = ad_in;
		end
		soft_nxt = soft_r;
		pio_nxt = pio_r;
		if (init_pulse) begin
			soft_nxt = host_port_pkg::SOFT_RESET_RST;
			pio_nxt = host_port_pkg::PIO_DIR_RST;
		end else if (wr_fire) begin
			if (addr_r == host_port_pkg::SOFT_RESET_OFS) begin
				soft_nxt = ad_in;
			end
			if (addr_r == host_port_pkg::PIO_DIR_OFS) begin
				pio_nxt = ad_in;
			end
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			as_d_r <= 1'b1;
			addr_r <= 9'h000;
			wr_done_r <= 1'b0;
			wdata_r <= 8'h00;
			soft_r <= host_port_pkg::SOFT_RESET_RST;
			pio_r <= host_port_pkg::PIO_DIR_RST;
		end else begin
			as_d_r <= as_d_nxt;
			addr_r <= addr_nxt;
			wr_done_r <= wr_done_nxt;
			wdata_r <= wdata_nxt;
			soft_r <= soft_nxt;
			pio_r <= pio_nxt;
		end
	end

	// general store for the remaining offsets
	genvar gi;
	generate
		for (gi = 0; gi < STORE_DEPTH; gi++) begin : g_store
			always_ff @(posedge clk_in or posedge rst_in) begin
				if (rst_in) begin
					store_r[gi] <= host_port_pkg::STORE_RST;
				end else if (init_pulse) begin
					store_r[gi] <= host_port_pkg::STORE_RST;
				end else if (wr_fire && addr_r[4:0] == 5'(gi) && addr_r != host_port_pkg::SOFT_RESET_OFS
					&& addr_r != host_port_pkg::PIO_DIR_OFS) begin
					store_r[gi] <= ad_in;
				end
			end
		end
	endgenerate

	// read mux
	always_comb begin
		if (addr_r == host_port_pkg::SOFT_RESET_OFS) begin
			rd_val = soft_r;
		end else if (addr_r == host_port_pkg::PIO_DIR_OFS) begin
			rd_val = pio_r;
		end else begin
			rd_val = store_r[addr_r[4:0]];
		end
	end

	// registered outputs
	logic [7:0] ad_out_r, ad_out_nxt;
	logic ad_oe_r, ad_oe_nxt;
	logic ack_oe_r, ack_oe_nxt;
	logic irq_oe_r, irq_oe_nxt;

	always_comb begin
		ad_oe_nxt = cyc_ok & rd_req;
		ad_out_nxt = rd_val;
		ack_oe_nxt = sync_mode & ~bus_style_select_in & ~as_n & ~cs_n;
		irq_oe_nxt = |irq_pending_in;
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ad_out_r <= 8'h00;
			ad_oe_r <= 1'b0;
			ack_oe_r <= 1'b0;
			irq_oe_r <= 1'b0;
		end else begin
			ad_out_r <= ad_out_nxt;
			ad_oe_r <= ad_oe_nxt;
			ack_oe_r <= ack_oe_nxt;
			irq_oe_r <= irq_oe_nxt;
		end
	end

	assign ad_out = ad_out_r;
	assign ad_oe_out = ad_oe_r;
	assign transfer_ack_n_out = 1'b0;
	assign transfer_ack_oe_out = ack_oe_r;
	assign interrupt_request_n_out = 1'b0;
	assign interrupt_request_oe_out = irq_oe_r;
	assign programmable_io_dir_out = pio_r;
	assign soft_reset_out = soft_r;
endmodule
`default_nettype wire

// >>> sim/framer_host_bus_port_chk.sv
// Purpose: port-level checks for the host bus port
// Assumes: straps change only while chip select is high
// Notes: attached to the design by bind
`timescale 1ns/10ps
`default_nettype none
module framer_host_bus_port_chk (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic hw_reset_n_in,
	// straps and host bus
	input wire logic bus_style_select_in,
	input wire logic sync_bus_select_in,
	input wire logic chip_select_n_in,
	input wire logic data_strobe_n_in,
	input wire logic [7:0] irq_pending_in,
	// outputs watched
	input wire logic ad_oe_out,
	input wire logic transfer_ack_n_out,
	input wire logic transfer_ack_oe_out,
	input wire logic interrupt_request_n_out,
	input wire logic interrupt_request_oe_out,
	input wire logic [7:0] programmable_io_dir_out,
	input wire logic [7:0] soft_reset_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	// reset forces defaults and a floating bus
	AST_POR: assert property (disable iff (1'b0) rst_in |-> !ad_oe_out && programmable_io_dir_out == 8'h00)
		else $error("outputs not at default in reset");
	AST_HWRST: assert property ($rose(hw_reset_n_in) |-> ##[1:4] programmable_io_dir_out == 8'h00 && soft_reset_out == 8'h00)
		else $error("registers not restored after host reset");
	AST_OD_LOW: assert property (!interrupt_request_n_out && !transfer_ack_n_out)
		else $error("open-drain output driven high");
	AST_INT_ON: assert property ((irq_pending_in != 8'h00) [*3] |-> interrupt_request_oe_out)
		else $error("interrupt request not driven");
	AST_INT_OFF: assert property ((irq_pending_in == 8'h00) [*3] |-> !interrupt_request_oe_out)
		else $error("interrupt request not released");
	AST_ACK_MODE: assert property (transfer_ack_oe_out |-> sync_bus_select_in && !bus_style_select_in)
		else $error("acknowledge outside sync separate-bus mode");
	AST_ACK_END: assert property (chip_select_n_in [*4] |-> !transfer_ack_oe_out)
		else $error("acknowledge held without chip select");
	AST_CS_FLOAT: assert property (chip_select_n_in [*4] |-> !ad_oe_out)
		else $error("data bus driven with chip select high");
	AST_OE_READ: assert property ($rose(ad_oe_out) |-> $past(!chip_select_n_in && !data_strobe_n_in, 2))
		else $error("read data driven without read strobe");
	// main scenarios reached
	COV_ACK: cover property ($rose(transfer_ack_oe_out));
	COV_READ: cover property ($rose(ad_oe_out));
	COV_INT: cover property ($rose(interrupt_request_oe_out));
endmodule
bind framer_host_bus_port framer_host_bus_port_chk chk (.*);
`default_nettype wire

// >>> sim/host_bus_model.sv
// Purpose: host processor bus controller model
// Assumes: each strobe phase lasts at least four clocks
// Notes: released data lines show the inverse of the last value
`timescale 1ns/10ps
`default_nettype none
module host_bus_model (
	// clock and strap
	input wire logic clk_in,
	input wire logic style_in,
	// read data from the port
	input wire logic [7:0] ad_out_in,
	input wire logic ad_oe_in,
	// host bus
	output logic [8:0] addr_out,
	output logic [7:0] ad_out,
	output logic as_n_out,
	output logic cs_n_out,
	output logic ds_n_out,
	output logic rw_n_out
);
	// bus idle at time zero
	initial begin
		{as_n_out, cs_n_out, ds_n_out, rw_n_out} = 4'hf;
		addr_out = 9'h000;
		ad_out = 8'h00;
	end
	// one bus cycle; style 1 puts the low address on the data lines
	task automatic cyc(input logic wr, input logic [8:0] a, input logic [7:0] d, output logic [7:0] q);
		addr_out <= style_in ? {a[8], ~a[7:0]} : a;
		ad_out <= style_in ? a[7:0] : ~d;
		as_n_out <= 1'b0;
		repeat (4) @(posedge clk_in);
		ad_out <= wr ? d : ~d;
		cs_n_out <= 1'b0;
		ds_n_out <= style_in & wr;
		rw_n_out <= !wr;
		repeat (8) @(posedge clk_in);
		q = ad_oe_in ? ad_out_in : 8'hxx;
		{as_n_out, cs_n_out, ds_n_out, rw_n_out} <= 4'hf;
		ad_out <= ~ad_out;
		repeat (4) @(posedge clk_in);
	endtask
endmodule
`default_nettype wire

// >>> sim/tb_framer_host_bus_port.sv
// Purpose: register access tests over three of the four bus modes, style 1 sync untested
// Assumes: a 50 MHz clock stands for both clock sources
// Notes: the processor clock tick runs only in external mode
`timescale 1ns/10ps
`default_nettype none
module tb_framer_host_bus_port;
	logic clk_in = 0, rst_in = 0, hw_reset_n_in = 1, proc_clk_tick_in = 0;
	logic bus_style_select_in = 0, sync_bus_select_in = 0, clock_source_select_in = 0;
	logic [8:0] addr_in;
	logic [7:0] ad_in, ad_out, q, irq_pending_in = 8'h00, programmable_io_dir_out, soft_reset_out;
	logic address_latch_strobe_n_in, chip_select_n_in, data_strobe_n_in, rd_wr_n_in, ad_oe_out;
	logic transfer_ack_n_out, transfer_ack_oe_out, interrupt_request_n_out, interrupt_request_oe_out;
	int bad_count = 0, check_count = 0;
	framer_host_bus_port dut (.*);
	host_bus_model host (.clk_in, .style_in(bus_style_select_in), .ad_out_in(ad_out), .ad_oe_in(ad_oe_out),
		.addr_out(addr_in), .ad_out(ad_in), .as_n_out(address_latch_strobe_n_in),
		.cs_n_out(chip_select_n_in), .ds_n_out(data_strobe_n_in), .rw_n_out(rd_wr_n_in));
	// clock and processor clock tick at half rate
	initial forever #10 clk_in = ~clk_in;
	always @(posedge clk_in) proc_clk_tick_in <= clock_source_select_in & ~proc_clk_tick_in;
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [8:0] a, input logic [7:0] e);
		host.cyc(1'b0, a, 8'h00, q);
		chk(q, e);
	endtask
	task automatic conclude();
		$display("checks=%0d mismatches=%0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// main sequence
	initial begin
		rst_in <= 1'b1; // rising edge at time zero resets every flop before the first clock
		repeat (12) @(posedge clk_in);
		rst_in <= 1'b0;
		repeat (4) @(posedge clk_in);
		rd(9'h001, 8'h00);
		rd(9'h018, 8'h00);
		for (int s = 0; s < 3; s++) begin
			bus_style_select_in <= s[0];
			sync_bus_select_in <= s[1];
			clock_source_select_in <= s[1];
			repeat (2) @(posedge clk_in);
			host.cyc(1'b1, 9'h018, 8'ha5 ^ s[7:0], q);
			host.cyc(1'b1, 9'h001, 8'h3c ^ s[7:0], q);
			host.cyc(1'b1, 9'h005, 8'h5a ^ s[7:0], q);
			rd(9'h018, 8'ha5 ^ s[7:0]);
			rd(9'h005, 8'h5a ^ s[7:0]);
			chk(programmable_io_dir_out, 8'ha5 ^ s[7:0]);
			chk(soft_reset_out, 8'h3c ^ s[7:0]);
		end
		hw_reset_n_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		hw_reset_n_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		chk(programmable_io_dir_out, 8'h00);
		rd(9'h005, 8'h00);
		irq_pending_in <= 8'h04;
		repeat (5) @(posedge clk_in);
		chk(8'(interrupt_request_oe_out), 8'h01);
		irq_pending_in <= 8'h00;
		repeat (5) @(posedge clk_in);
		chk(8'(interrupt_request_oe_out), 8'h00);
		conclude();
	end
	// cut a hang short
	initial begin
		repeat (5000) @(posedge clk_in);
		bad_count++;
		conclude();
	end
endmodule
`default_nettype wire
